// File: core/dcr_pkg.sv
package dcr_pkg;
	// byte offsets in the converter window
	localparam logic [3:0] OFF_CTL_A    = 4'h0;
	localparam logic [3:0] OFF_CTL_B    = 4'h1;
	localparam logic [3:0] OFF_EVT      = 4'h2;
	localparam logic [3:0] OFF_IEN_CLR  = 4'h4;
	localparam logic [3:0] OFF_IEN_SET  = 4'h5;
	localparam logic [3:0] OFF_FLAGS    = 4'h6;
	localparam logic [3:0] OFF_STATUS   = 4'h7;
	localparam logic [3:0] OFF_VALUE    = 4'h8;
	localparam logic [3:0] OFF_VALUE_HI = 4'h9;
	localparam logic [3:0] OFF_BUF      = 4'hC;
	localparam logic [3:0] OFF_BUF_HI   = 4'hD;
	// field positions
	localparam int CA_SOFT_RESET = 0;
	localparam int CA_ENABLE     = 1;
	localparam int CA_STBY       = 2;
	localparam int CB_EXT_OUT    = 0;
	localparam int CB_INT_OUT    = 1;
	localparam int CB_ALIGN      = 2;
	localparam int CB_PUMP       = 3;
	localparam int CB_REF_LSB    = 6;
	localparam int EV_START_IN   = 0;
	localparam int EV_EMPTY_OUT  = 1;
	localparam int IRQ_UNDER     = 0;
	localparam int IRQ_EMPTY     = 1;
	localparam int IRQ_SYNC      = 2;
	localparam int ST_BUSY       = 7;
	// reference select codes, 2'h3 is reserved
	localparam logic [1:0] REF_INT_1V = 2'h0;
	localparam logic [1:0] REF_SUPPLY = 2'h1;
	localparam logic [1:0] REF_EXT    = 2'h2;
	// cycles taken by a write to cross into the converter domain
	localparam int SYNC_CYCLES = 3;
	localparam int CODE_W      = 10;

	typedef enum logic [1:0] {
		OP_NONE   = 2'b00,
		OP_ENABLE = 2'b01,
		OP_RESET  = 2'b10,
		OP_VALUE  = 2'b11
	} dcr_op_e;

	typedef struct packed {
		logic              stby;
		logic              enable;
		logic              software_reset;
		logic              en_act;
		logic [1:0]        reference_select;
		logic              pump_disable;
		logic              left;
		logic              internal_output_enable;
		logic              external_output_enable;
		logic              empty_event_output;
		logic              start_event_input;
		logic [2:0]        inten;
		logic [2:0]        flag;
		logic              busy;
		dcr_op_e           op;
		logic [3:0]        cnt;
		logic [15:0]       pend;
		logic              pend_buf;
		logic [15:0]       data;
		logic [15:0]       buff;
		logic              full;
		logic [CODE_W-1:0] code;
		logic              ext_buf;
		logic              empty_ev;
		logic              irq;
		logic              ack;
		logic [15:0]       rdata;
	} dcr_st_s;

	// every field of the block clears to zero
	localparam dcr_st_s ST_RST = '0;
endpackage

// File: core/dcr_bank.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_bank
	import dcr_pkg::*;
#(
	parameter int SYNC_LEN = SYNC_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic        size16_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        prot_i,
	input  wire logic        standby_i,
	input  wire logic        start_ev_i,
	output logic             ack_o,
	output logic [15:0]      rdata_o,
	output logic             busy_o,
	output logic             irq_o,
	output logic             conv_en_o,
	output logic [9:0]       code_o,
	output logic [1:0]       ref_sel_o,
	output logic             pump_dis_o,
	output logic             int_out_o,
	output logic             ext_buf_o,
	output logic             empty_ev_o
);

	dcr_st_s     s_ff;
	dcr_st_s     nxt_s;
	logic        take;
	logic        wr;
	logic        need_sync;
	logic        wr_ca;
	logic        rst_wr;
	logic [7:0]  ca;
	logic [2:0]  set_fl;
	logic [2:0]  clr_fl;
	logic [3:0]  a_hi;
	logic [7:0]  cb_b;
	logic [7:0]  ev_b;
	logic [7:0]  ic_b;
	logic [7:0]  is_b;
	logic [7:0]  fl_b;

	// byte lane hit for one 8-bit location
	function automatic logic bhit(logic [3:0] a, logic sz, logic [3:0] off);
		return (a == off) || (sz && ((a + 4'h1) == off));
	endfunction

	// byte carried to one location by the write
	function automatic logic [7:0] bdat(logic [3:0] a, logic [15:0] w, logic [3:0] off);
		return (a == off) ? w[7:0] : w[15:8];
	endfunction

	// read view of one byte location
	function automatic logic [7:0] rd_byte(dcr_st_s s, logic [3:0] a);
		logic [7:0] b;
		b = 8'h00;
		case (a)
			OFF_CTL_A: begin
				b = {5'h00, s.stby, s.enable, s.software_reset};
			end
			OFF_CTL_B: begin
				b = {s.reference_select, 2'h0, s.pump_disable, s.left, s.internal_output_enable, s.external_output_enable};
			end
			OFF_EVT: begin
				b = {6'h00, s.empty_event_output, s.start_event_input};
			end
			OFF_IEN_CLR, OFF_IEN_SET: begin
				b = {5'h00, s.inten};
			end
			OFF_FLAGS: begin
				b = {5'h00, s.flag};
			end
			OFF_STATUS: begin
				b = {s.busy, 7'h00};
			end
			OFF_VALUE: begin
				b = s.data[7:0];
			end
			OFF_VALUE_HI: begin
				b = s.data[15:8];
			end
			OFF_BUF: begin
				b = s.buff[7:0];
			end
			OFF_BUF_HI: begin
				b = s.buff[15:8];
			end
			default: begin
				b = 8'h00;
			end
		endcase
		return b;
	endfunction

	// request decode; sync writes wait while a crossing is in flight
	always_comb begin
		a_hi = addr_i + 4'h1;
		ca = bdat(addr_i, wdata_i, OFF_CTL_A);
		// one byte per register, so fields can be picked without selecting a call
		cb_b = bdat(addr_i, wdata_i, OFF_CTL_B);
		ev_b = bdat(addr_i, wdata_i, OFF_EVT);
		ic_b = bdat(addr_i, wdata_i, OFF_IEN_CLR);
		is_b = bdat(addr_i, wdata_i, OFF_IEN_SET);
		fl_b = bdat(addr_i, wdata_i, OFF_FLAGS);
		wr_ca = we_i && !prot_i && bhit(addr_i, size16_i, OFF_CTL_A);
		need_sync = we_i && !prot_i && (
			(wr_ca && (ca[CA_SOFT_RESET] || (ca[CA_ENABLE] != s_ff.enable))) ||
			bhit(addr_i, size16_i, OFF_VALUE) || bhit(addr_i, size16_i, OFF_VALUE_HI) ||
			bhit(addr_i, size16_i, OFF_BUF) || bhit(addr_i, size16_i, OFF_BUF_HI));
		take = req_i && !(need_sync && s_ff.busy);
		wr = take && we_i && !prot_i;
		rst_wr = take && wr_ca && ca[CA_SOFT_RESET];
	end

	// next state of the whole block
	always_comb begin
		nxt_s = s_ff;
		nxt_s.ack = 1'b0;
		nxt_s.empty_ev = 1'b0;
		set_fl = 3'h0;
		clr_fl = 3'h0;
		// start event moves buffer into the value register
		if (start_ev_i && s_ff.start_event_input) begin
			if (s_ff.full) begin
				nxt_s.data = s_ff.buff;
				nxt_s.full = 1'b0;
				set_fl[IRQ_EMPTY] = 1'b1;
				nxt_s.empty_ev = s_ff.empty_event_output;
			end else begin
				set_fl[IRQ_UNDER] = 1'b1;
			end
		end
		// crossing countdown and its completion
		if (s_ff.busy) begin
			nxt_s.cnt = s_ff.cnt - 4'h1;
			if (s_ff.cnt <= 4'h1) begin
				nxt_s.busy = 1'b0;
				nxt_s.op = OP_NONE;
				case (s_ff.op)
					OP_ENABLE: begin
						nxt_s.en_act = s_ff.enable;
					end
					OP_VALUE: begin
						if (s_ff.pend_buf) begin
							nxt_s.buff = s_ff.pend;
							nxt_s.full = 1'b1;
							clr_fl[IRQ_EMPTY] = 1'b1;
						end else begin
							nxt_s.data = s_ff.pend;
						end
						set_fl[IRQ_SYNC] = 1'b1;
					end
					default: begin
						nxt_s.en_act = s_ff.en_act;
					end
				endcase
			end
		end
		// register writes, skipped whole when soft reset is requested
		if (wr && !rst_wr) begin
			if (wr_ca) begin
				nxt_s.stby = ca[CA_STBY];
				nxt_s.enable = ca[CA_ENABLE];
				if (ca[CA_ENABLE] != s_ff.enable) begin
					nxt_s.busy = 1'b1;
					nxt_s.op = OP_ENABLE;
					nxt_s.cnt = 4'(SYNC_LEN);
				end
			end
			if (bhit(addr_i, size16_i, OFF_CTL_B)) begin
				nxt_s.reference_select = cb_b[CB_REF_LSB +: 2];
				nxt_s.pump_disable = cb_b[CB_PUMP];
				nxt_s.left = cb_b[CB_ALIGN];
				nxt_s.internal_output_enable = cb_b[CB_INT_OUT];
				nxt_s.external_output_enable = cb_b[CB_EXT_OUT];
			end
			if (bhit(addr_i, size16_i, OFF_EVT)) begin
				nxt_s.empty_event_output = ev_b[EV_EMPTY_OUT];
				nxt_s.start_event_input = ev_b[EV_START_IN];
			end
			if (bhit(addr_i, size16_i, OFF_IEN_CLR)) begin
				nxt_s.inten = nxt_s.inten & ~ic_b[2:0];
			end
			if (bhit(addr_i, size16_i, OFF_IEN_SET)) begin
				nxt_s.inten = nxt_s.inten | is_b[2:0];
			end
			if (bhit(addr_i, size16_i, OFF_FLAGS)) begin
				clr_fl = clr_fl | fl_b[2:0];
			end
			// value and buffer writes cross before they land
			if (bhit(addr_i, size16_i, OFF_VALUE) || bhit(addr_i, size16_i, OFF_VALUE_HI) ||
				bhit(addr_i, size16_i, OFF_BUF) || bhit(addr_i, size16_i, OFF_BUF_HI)) begin
				nxt_s.pend_buf = bhit(addr_i, size16_i, OFF_BUF) ||
					bhit(addr_i, size16_i, OFF_BUF_HI);
				nxt_s.pend = nxt_s.pend_buf ? s_ff.buff : s_ff.data;
				if (bhit(addr_i, size16_i, OFF_VALUE) || bhit(addr_i, size16_i, OFF_BUF)) begin
					nxt_s.pend[7:0] = wdata_i[7:0];
				end
				if (bhit(addr_i, size16_i, OFF_VALUE_HI) ||
					bhit(addr_i, size16_i, OFF_BUF_HI)) begin
					nxt_s.pend[15:8] = (addr_i[0]) ? wdata_i[7:0] : wdata_i[15:8];
				end
				nxt_s.busy = 1'b1;
				nxt_s.op = OP_VALUE;
				nxt_s.cnt = 4'(SYNC_LEN);
			end
		end
		// hardware set wins over a software clear
		nxt_s.flag = (s_ff.flag & ~clr_fl) | set_fl;
		// soft reset: clear everything but the read data now, hold the bit until crossing ends
		if (rst_wr) begin
			nxt_s = ST_RST;
			nxt_s.software_reset = 1'b1;
			nxt_s.busy = 1'b1;
			nxt_s.op = OP_RESET;
			nxt_s.cnt = 4'(SYNC_LEN);
		end else if (s_ff.busy && (s_ff.cnt <= 4'h1) && (s_ff.op == OP_RESET)) begin
			nxt_s = ST_RST;
		end
		// converter-facing outputs
		nxt_s.code = nxt_s.left ? nxt_s.data[15:6] : nxt_s.data[9:0];
		nxt_s.ext_buf = nxt_s.external_output_enable && nxt_s.en_act && !(standby_i && !nxt_s.stby);
		nxt_s.irq = |(nxt_s.flag & nxt_s.inten);
		// bus answer
		nxt_s.ack = take;
		nxt_s.rdata = s_ff.rdata;
		if (take && !we_i) begin
			nxt_s.rdata = {size16_i ? rd_byte(s_ff, a_hi) : 8'h00, rd_byte(s_ff, addr_i)};
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_ff <= ST_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign ack_o      = s_ff.ack;
	assign rdata_o    = s_ff.rdata;
	assign busy_o     = s_ff.busy;
	assign irq_o      = s_ff.irq;
	assign conv_en_o  = s_ff.en_act;
	assign code_o     = s_ff.code;
	assign ref_sel_o  = s_ff.reference_select;
	assign pump_dis_o = s_ff.pump_disable;
	assign int_out_o  = s_ff.internal_output_enable;
	assign ext_buf_o  = s_ff.ext_buf;
	assign empty_ev_o = s_ff.empty_ev;

	// checks on the block's own outputs and internal state
	default clocking dcr_cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	ctla_resv_a: assert property (take && !we_i && addr_i == OFF_CTL_A |=> rdata_o[7:3] == 5'h00)
		else $error("control A reserved bits not zero");
	stby_off_a: assert property (standby_i && !nxt_s.stby |=> !ext_buf_o)
		else $error("buffer on in standby without retention");
	stby_nosync_a: assert property (wr && wr_ca && !rst_wr && ca[CA_ENABLE] == s_ff.enable && !s_ff.busy
		&& !need_sync |=> !busy_o)
		else $error("retention write started a crossing");
	en_busy_a: assert property (wr && wr_ca && !rst_wr && ca[CA_ENABLE] != s_ff.enable
		|=> busy_o && s_ff.enable == $past(ca[CA_ENABLE]) ##3 !busy_o && conv_en_o == s_ff.enable)
		else $error("enable crossing wrong");
	rst_seq_a: assert property (rst_wr |=> s_ff.software_reset && busy_o && !conv_en_o && s_ff.inten == 3'h0
		##3 !s_ff.software_reset && !busy_o)
		else $error("soft reset sequence wrong");
	ien_set_a: assert property (wr && bhit(addr_i, size16_i, OFF_IEN_SET) && !rst_wr
		&& is_b[IRQ_SYNC] |=> s_ff.inten[IRQ_SYNC])
		else $error("enable set lost");
	ien_clr_a: assert property (wr && bhit(addr_i, size16_i, OFF_IEN_CLR) && !rst_wr
		&& !bhit(addr_i, size16_i, OFF_IEN_SET)
		&& ic_b[IRQ_SYNC] |=> !s_ff.inten[IRQ_SYNC])
		else $error("enable clear lost");
	under_flag_a: assert property (start_ev_i && s_ff.start_event_input && !s_ff.full && !rst_wr
		&& !(s_ff.busy && s_ff.op == OP_RESET) |=> s_ff.flag[IRQ_UNDER])
		else $error("underrun not flagged");
	empty_ev_a: assert property (start_ev_i && s_ff.start_event_input && s_ff.full && !rst_wr
		&& !(s_ff.busy && s_ff.op == OP_RESET) |=> empty_ev_o == $past(s_ff.empty_event_output)
		&& s_ff.data == $past(s_ff.buff))
		else $error("buffer move or empty event wrong");
	irq_pair_a: assert property (irq_o == |(s_ff.flag & s_ff.inten))
		else $error("interrupt line mismatch");
	prot_hold_a: assert property (req_i && we_i && prot_i |=> $stable(ref_sel_o))
		else $error("protected write took effect");
	code_sel_a: assert property (code_o == (s_ff.left ? s_ff.data[15:6] : s_ff.data[9:0]))
		else $error("converter code misaligned");
	unmap_a: assert property (take && !we_i && !size16_i && addr_i == 4'h3 |=> rdata_o == 16'h0000)
		else $error("unmapped offset not zero");
	// control B outputs, crossing completion and stall
	ctlb_out_a: assert property (wr && bhit(addr_i, size16_i, OFF_CTL_B) && !rst_wr
		&& !(s_ff.busy && s_ff.op == OP_RESET) |=> ref_sel_o == $past(cb_b[7:6])
		&& pump_dis_o == $past(cb_b[CB_PUMP]) && int_out_o == $past(cb_b[CB_INT_OUT]))
		else $error("control B outputs wrong");
	sync_rdy_a: assert property (s_ff.busy && s_ff.cnt <= 4'h1 && s_ff.op == OP_VALUE
		|=> s_ff.flag[IRQ_SYNC])
		else $error("sync ready not flagged");
	no_rdy_a: assert property (s_ff.busy && s_ff.cnt <= 4'h1 && s_ff.op == OP_ENABLE
		&& !s_ff.flag[IRQ_SYNC] |=> !s_ff.flag[IRQ_SYNC])
		else $error("sync ready set by enable");
	empty_clr_a: assert property (s_ff.busy && s_ff.cnt <= 4'h1 && s_ff.op == OP_VALUE
		&& s_ff.pend_buf && !start_ev_i |=> s_ff.full && !s_ff.flag[IRQ_EMPTY])
		else $error("buffer write left empty flag");
	sync_stall_a: assert property (req_i && need_sync && s_ff.busy |=> !ack_o)
		else $error("sync write taken while busy");

	move_c: cover property (start_ev_i && s_ff.start_event_input && s_ff.full);
	rst_c: cover property (rst_wr ##4 !busy_o);
	stall_c: cover property (req_i && need_sync && busy_o);
	sync_rdy_c: cover property (s_ff.busy && s_ff.cnt == 4'h1 && s_ff.op == OP_VALUE);
	under_c: cover property (start_ev_i && s_ff.start_event_input && !s_ff.full);
endmodule
`default_nettype wire

// File: sim/dcr_evt_src.sv
`timescale 1ns/1ps
`default_nettype none
// event system stand-in: turns a bench request into one start pulse and
// tallies the buffer-empty pulses coming back
module dcr_evt_src (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       fire_i,
	input  wire logic       empty_ev_i,
	output logic            start_ev_o,
	output logic [7:0]      empty_cnt_o
);
	// one-cycle start pulse and empty event tally
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			start_ev_o  <= 1'b0;
			empty_cnt_o <= 8'h00;
		end else begin
			start_ev_o <= fire_i;
			if (empty_ev_i) begin
				empty_cnt_o <= empty_cnt_o + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dcr_pkg::*;
	logic        clk_i, rstn_i, req_i, we_i, size16_i, prot_i, standby_i, fire;
	logic [3:0]  addr_i;
	logic [15:0] wdata_i, rdata_o, rd;
	logic        ack_o, busy_o, irq_o, conv_en_o;
	logic [9:0]  code_o;
	logic [1:0]  ref_sel_o;
	logic        pump_dis_o, int_out_o, ext_buf_o, empty_ev_o, start_ev;
	logic [7:0]  empty_cnt;
	int          miscompares, n_compared, cycles;
	logic [3:0]  zero_offs [12] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7,
		4'h3, 4'hA, 4'hB, 4'hE, 4'hF};

	dcr_bank u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .we_i(we_i),
		.size16_i(size16_i), .addr_i(addr_i), .wdata_i(wdata_i), .prot_i(prot_i),
		.standby_i(standby_i), .start_ev_i(start_ev), .ack_o(ack_o), .rdata_o(rdata_o),
		.busy_o(busy_o), .irq_o(irq_o), .conv_en_o(conv_en_o), .code_o(code_o),
		.ref_sel_o(ref_sel_o), .pump_dis_o(pump_dis_o), .int_out_o(int_out_o),
		.ext_buf_o(ext_buf_o), .empty_ev_o(empty_ev_o));
	dcr_evt_src u_evt (.clk_i(clk_i), .rstn_i(rstn_i), .fire_i(fire),
		.empty_ev_i(empty_ev_o), .start_ev_o(start_ev), .empty_cnt_o(empty_cnt));

	// clock and hang guard
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one bus access; writes wait for the crossing to finish so they are never stalled
	task automatic xfer(input logic we, input logic sz, input logic [3:0] a,
		input logic [15:0] wd);
		int n;
		n = 0;
		while (we && busy_o !== 1'b0 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		req_i   <= 1'b1;
		we_i    <= we;
		size16_i <= sz;
		addr_i  <= a;
		wdata_i <= wd;
		@(posedge clk_i);
		req_i <= 1'b0;
		@(posedge clk_i);
		chk({15'h0000, ack_o}, 16'h0001);
		rd = rdata_o;
	endtask

	// even offsets from 8 up go 16-bit, which covers the value and buffer words; all else byte-wide
	task automatic wr(input logic [3:0] a, input logic [15:0] wd);
		xfer(1'b1, a[3] && !a[0], a, wd);
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		xfer(1'b0, a[3] && !a[0], a, 16'h0000);
		chk(rd, exp);
	endtask

	// synchronised write issued while busy: hold the request until the answer comes
	task automatic wr_stall(input logic [3:0] a, input logic [15:0] wd);
		int n;
		n = 0;
		req_i    <= 1'b1;
		we_i     <= 1'b1;
		size16_i <= a[3] && !a[0];
		addr_i   <= a;
		wdata_i  <= wd;
		@(posedge clk_i);
		while (ack_o !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		req_i <= 1'b0;
		chk({15'h0000, ack_o}, 16'h0001);
	endtask

	// wait for the crossing to finish, bounded
	task automatic idle();
		int n;
		n = 0;
		while (busy_o !== 1'b0 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		@(posedge clk_i);
	endtask

	// start event through the partner, then code_o has settled
	task automatic strike();
		fire <= 1'b1;
		@(posedge clk_i);
		fire <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	// main sequence
	initial begin
		{rstn_i, req_i, we_i, size16_i, prot_i, standby_i, fire} = '0;
		addr_i = 4'h0;
		wdata_i = 16'h0000;
		miscompares = 0;
		n_compared = 0;
		cycles = 0;
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		foreach (zero_offs[i]) rd_chk(zero_offs[i], 16'h0000);
		rd_chk(OFF_VALUE, 16'h0000);
		$display("test reset_values done");
		for (int r = 0; r < 4; r++) begin
			wr(OFF_CTL_B, {8'h00, r[1:0], 6'h3F});
			rd_chk(OFF_CTL_B, {8'h00, r[1:0], 6'h0F});
			chk({14'h0000, ref_sel_o}, {14'h0000, r[1:0]});
			chk({14'h0000, pump_dis_o, int_out_o}, 16'h0003);
		end
		wr(OFF_CTL_B, 16'h0000);
		chk({14'h0000, pump_dis_o, int_out_o}, 16'h0000);
		$display("test control_b done");
		wr(OFF_IEN_SET, 16'h0007);
		rd_chk(OFF_IEN_CLR, 16'h0007);
		wr(OFF_IEN_CLR, 16'h0004);
		rd_chk(OFF_IEN_SET, 16'h0003);
		wr(OFF_IEN_CLR, 16'h00FB);
		rd_chk(OFF_IEN_SET, 16'h0000);
		$display("test enables done");
		wr(OFF_CTL_A, 16'h00FA);
		chk({15'h0000, busy_o}, 16'h0001);
		rd_chk(OFF_CTL_A, 16'h0002);
		idle();
		chk({15'h0000, conv_en_o}, 16'h0001);
		rd_chk(OFF_FLAGS, 16'h0000);
		$display("test enable done");
		wr(OFF_IEN_SET, 16'h0004);
		wr(OFF_EVT, 16'h0003);
		wr(OFF_BUF, 16'h0155);
		idle();
		rd_chk(OFF_FLAGS, 16'h0004);
		chk({15'h0000, irq_o}, 16'h0001);
		wr(OFF_FLAGS, 16'h0004);
		chk({15'h0000, irq_o}, 16'h0000);
		strike();
		chk({6'h00, code_o}, 16'h0155);
		rd_chk(OFF_VALUE, 16'h0155);
		rd_chk(OFF_FLAGS, 16'h0002);
		chk({8'h00, empty_cnt}, 16'h0001);
		strike();
		rd_chk(OFF_FLAGS, 16'h0003);
		wr(OFF_BUF, 16'h0007);
		idle();
		rd_chk(OFF_FLAGS, 16'h0005);
		wr(OFF_CTL_B, 16'h0004);
		wr(OFF_BUF, 16'h8FC0);
		idle();
		strike();
		chk({6'h00, code_o}, 16'h023F);
		$display("test events done");
		wr(OFF_VALUE, 16'h0123);
		wr_stall(OFF_VALUE_HI, 16'h0002);
		idle();
		rd_chk(OFF_VALUE, 16'h0223);
		$display("test halves done");
		wr(OFF_CTL_B, 16'h0001);
		wr(OFF_CTL_A, 16'h0006);
		standby_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({15'h0000, ext_buf_o}, 16'h0001);
		wr(OFF_CTL_A, 16'h0002);
		chk({15'h0000, busy_o}, 16'h0000);
		@(posedge clk_i);
		chk({15'h0000, ext_buf_o}, 16'h0000);
		standby_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({15'h0000, ext_buf_o}, 16'h0001);
		wr(OFF_CTL_B, 16'h0000);
		@(posedge clk_i);
		chk({15'h0000, ext_buf_o}, 16'h0000);
		$display("test standby done");
		prot_i <= 1'b1;
		wr(OFF_CTL_B, 16'h000C);
		rd_chk(OFF_CTL_B, 16'h0000);
		prot_i <= 1'b0;
		$display("test protection done");
		wr(OFF_CTL_B, 16'h0080);
		wr(OFF_CTL_A, 16'h0003);
		rd_chk(OFF_CTL_A, 16'h0001);
		chk({15'h0000, busy_o}, 16'h0001);
		idle();
		rd_chk(OFF_CTL_A, 16'h0000);
		rd_chk(OFF_CTL_B, 16'h0000);
		rd_chk(OFF_FLAGS, 16'h0000);
		chk({15'h0000, conv_en_o}, 16'h0000);
		$display("test soft_reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
